/* File: hw/fcp_consts.vh */
// Constants for the flash command and protection host controller.
// Assumes a 20 MHz system clock and a byte-wide parallel flash outside.
`ifndef FCP_CONSTS_VH
`define FCP_CONSTS_VH
// ==========================================================
// Register map, AXI4-Lite byte offsets
`define FCP_REG_CMD      8'h00
`define FCP_REG_ADDR     8'h04
`define FCP_REG_WDATA    8'h08
`define FCP_REG_RDATA    8'h0c
`define FCP_REG_STATUS   8'h10
`define FCP_REG_CFG      8'h14
`define FCP_REG_PSEL     8'h18
// ==========================================================
// Operation codes in the command register
`define FCP_OP_NONE      3'h0
`define FCP_OP_READ      3'h1
`define FCP_OP_WRITE     3'h2
`define FCP_OP_RESET     3'h3
`define FCP_OP_CMDSEQ    3'h4
`define FCP_OP_HVREAD    3'h5
`define FCP_OP_PROTCHK   3'h6
`define FCP_OP_IDSEQ     3'h7
// ==========================================================
// Status bits
`define FCP_ST_BUSY      0
`define FCP_ST_IDMODE    1
`define FCP_ST_FAIL      2
`define FCP_ST_REFUSED   3
`define FCP_ST_DONE      4
// Configuration fields
`define FCP_CFG_AUTO     8
`define FCP_CFG_RST_DEF  8'hff
// ==========================================================
// Flash address and data fields
`define FCP_FAIL_BIT     5
`define FCP_SEC_HI       18
`define FCP_SEC_LO       16
`define FCP_MAKER_LOW    16'h0000
`define FCP_PART_LOW     16'h0001
`define FCP_PROT_LOW     16'h0002
// ==========================================================
// Timing
`define FCP_CLK_MHZ      20
`define FCP_T_ACC_NS     100
`define FCP_T_WP_NS      100
`define FCP_T_GLITCH_NS  5
`define FCP_CYC_UP(ns)   (((ns) * `FCP_CLK_MHZ + 999) / 1000)
`define FCP_RESP_OKAY    2'b00
`define FCP_RESP_SLVERR  2'b10
`endif

/* File: hw/fcp_prot_mem.v */
// Eight-entry store of sector protection readback bytes.
// Assumes one writer and one reader on the system clock.
`timescale 1ns/100ps
module fcp_prot_mem (
   input  wire       i_clk_sys,
   input  wire       i_rstn,
   input  wire       i_we,
   input  wire [2:0] i_waddr,
   input  wire [7:0] i_wdata,
   input  wire [2:0] i_raddr,
   output reg  [7:0] o_rdata_q
);
   reg [7:0] mem_q [0:7];
   // ==========================================================
   // Storage, all entries read unprotected after reset
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_ent
         always @(posedge i_clk_sys or negedge i_rstn) begin
            if (!i_rstn) begin
               mem_q[g] <= 8'h00;
            end else if (i_we && (i_waddr == g)) begin
               mem_q[g] <= i_wdata;
            end
         end
      end
   endgenerate
   // ==========================================================
   // Registered read port
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata_q <= 8'h00;
      end else begin
         o_rdata_q <= mem_q[i_raddr];
      end
   end
endmodule

/* File: hw/fcp_host.v */
// Host controller driving a byte-wide parallel flash through its pins.
// Assumes AXI4-Lite software access and pins synchronous to i_clk_sys.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "fcp_consts.vh"
module fcp_host #(
   parameter [18:0] UNLK_A1 = 19'h00000,
   parameter [7:0]  UNLK_D1 = 8'h00,
   parameter [18:0] UNLK_A2 = 19'h00000,
   parameter [7:0]  UNLK_D2 = 8'h00
) (
   input  wire        i_clk_sys,
   input  wire        i_rstn,
   input  wire [7:0]  i_awaddr,
   input  wire        i_awvalid,
   output reg         o_awready,
   input  wire [31:0] i_wdata,
   input  wire [3:0]  i_wstrb,
   input  wire        i_wvalid,
   output reg         o_wready,
   output reg  [1:0]  o_bresp,
   output reg         o_bvalid,
   input  wire        i_bready,
   input  wire [7:0]  i_araddr,
   input  wire        i_arvalid,
   output reg         o_arready,
   output reg  [31:0] o_rdata,
   output reg  [1:0]  o_rresp,
   output reg         o_rvalid,
   input  wire        i_rready,
   output reg  [18:0] o_addr,
   output reg         o_ce_n,
   output reg         o_oe_n,
   output reg         o_we_n,
   output reg  [7:0]  o_dq_o,
   output reg         o_dq_oe,
   input  wire [7:0]  i_dq_i,
   output reg         o_hv_id,
   input  wire        i_supply_low
);
   localparam integer ACC_I   = `FCP_CYC_UP(`FCP_T_ACC_NS);
   localparam integer GL_I    = `FCP_CYC_UP(`FCP_T_GLITCH_NS) + 1;
   localparam integer WP_I    = `FCP_CYC_UP(`FCP_T_WP_NS);
   localparam [7:0]   ACC_CYC = ACC_I[7:0];
   localparam [7:0]   GL_CYC  = GL_I[7:0];
   localparam [7:0]   WP_CYC  = (WP_I > GL_I) ? WP_I[7:0] : GL_I[7:0];
   localparam [5:0] S_IDLE  = 6'h01;
   localparam [5:0] S_WSET  = 6'h02;
   localparam [5:0] S_WPUL  = 6'h04;
   localparam [5:0] S_WHLD  = 6'h08;
   localparam [5:0] S_RACC  = 6'h10;
   localparam [5:0] S_GAP   = 6'h20;

   reg [7:0]  aw_addr_q;
   reg        aw_got_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;
   reg        w_got_q;
   reg [2:0]  op_q;
   reg [18:0] addr_q;
   reg [7:0]  wdat_q;
   reg [7:0]  rdat_q;
   reg [8:0]  cfg_q;
   reg [2:0]  psel_q;
   reg        idm_q;
   reg        fail_q;
   reg        ref_q;
   reg        done_q;
   reg [5:0]  st_q;
   reg [7:0]  cnt_q;
   reg [1:0]  step_q;
   reg        rd_q;
   reg        hv_q;
   reg        fail_hit_q;
   wire [7:0] pm_rdata;
   wire [31:0] wmask;

   // ==========================================================
   // Byte lane mask
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         assign wmask[g*8+7:g*8] = {8{w_strb_q[g]}};
      end
   endgenerate

   // ==========================================================
   // AXI4-Lite write and read channels
   wire do_wr = aw_got_q && w_got_q && !o_bvalid;
   wire [31:0] wv = w_data_q & wmask;
   wire wr_cmd = do_wr && (aw_addr_q == `FCP_REG_CMD) && w_strb_q[0];
   wire busy = (st_q != S_IDLE);
   reg  [31:0] rmux;
   reg         rok;
   always @* begin
      rmux = 32'h0000_0000;
      rok  = 1'b1;
      case (i_araddr)
         `FCP_REG_CMD:    rmux = {29'h0000_0000, op_q};
         `FCP_REG_ADDR:   rmux = {13'h0000, addr_q};
         `FCP_REG_WDATA:  rmux = {24'h00_0000, wdat_q};
         `FCP_REG_RDATA:  rmux = {24'h00_0000, rdat_q};
         `FCP_REG_STATUS: rmux = {27'h000_0000, done_q, ref_q, fail_q, idm_q, busy};
         `FCP_REG_CFG:    rmux = {23'h00_0000, cfg_q};
         `FCP_REG_PSEL:   rmux = {21'h00_0000, psel_q, pm_rdata};
         default:         rok  = 1'b0;
      endcase
   end

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         o_bvalid  <= 1'b0;
         o_bresp   <= `FCP_RESP_OKAY;
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= `FCP_RESP_OKAY;
      end else begin
         o_awready <= !aw_got_q && !(i_awvalid && o_awready) && !o_bvalid;
         o_wready  <= !w_got_q && !(i_wvalid && o_wready) && !o_bvalid;
         if (i_awvalid && o_awready) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_got_q  <= 1'b1;
            w_data_q <= i_wdata;
            w_strb_q <= i_wstrb;
         end
         if (do_wr) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp  <= (aw_addr_q == `FCP_REG_CMD || aw_addr_q == `FCP_REG_ADDR ||
                         aw_addr_q == `FCP_REG_WDATA || aw_addr_q == `FCP_REG_STATUS ||
                         aw_addr_q == `FCP_REG_CFG || aw_addr_q == `FCP_REG_PSEL ||
                         aw_addr_q == `FCP_REG_RDATA) ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
         o_arready <= !o_rvalid && !(i_arvalid && o_arready);
         if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rmux;
            o_rresp  <= rok ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Software registers
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         addr_q <= 19'h0_0000;
         wdat_q <= 8'h00;
         cfg_q  <= {1'b0, `FCP_CFG_RST_DEF};
         psel_q <= 3'h0;
      end else if (do_wr) begin
         if (aw_addr_q == `FCP_REG_ADDR) begin
            addr_q <= (addr_q & ~wmask[18:0]) | wv[18:0];
         end
         if (aw_addr_q == `FCP_REG_WDATA) begin
            wdat_q <= (wdat_q & ~wmask[7:0]) | wv[7:0];
         end
         if (aw_addr_q == `FCP_REG_CFG) begin
            cfg_q <= (cfg_q & ~wmask[8:0]) | wv[8:0];
         end
         if (aw_addr_q == `FCP_REG_PSEL && w_strb_q[1]) begin
            psel_q <= w_data_q[10:8];
         end
      end
   end

   // ==========================================================
   // Flash cycle sequencer
   wire last_step = (step_q == 2'h2) || (op_q == `FCP_OP_WRITE) || (op_q == `FCP_OP_RESET);
   wire is_wop = (wdata_op(w_data_q[2:0]));
   wire fail_hit = rd_q && !hv_q && cfg_q[`FCP_CFG_AUTO] && i_dq_i[`FCP_FAIL_BIT];
   wire rd_end = (st_q == S_RACC) && (cnt_q == 8'h00);
   wire clr_st = do_wr && (aw_addr_q == `FCP_REG_STATUS) && w_strb_q[0];

   function wdata_op;
      input [2:0] op;
      begin
         wdata_op = (op == `FCP_OP_WRITE) || (op == `FCP_OP_RESET) ||
                    (op == `FCP_OP_CMDSEQ) || (op == `FCP_OP_IDSEQ);
      end
   endfunction

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q    <= S_IDLE;
         op_q    <= `FCP_OP_NONE;
         cnt_q   <= 8'h00;
         step_q  <= 2'h0;
         rd_q    <= 1'b0;
         hv_q    <= 1'b0;
         o_addr  <= 19'h0_0000;
         o_ce_n  <= 1'b1;
         o_oe_n  <= 1'b1;
         o_we_n  <= 1'b1;
         o_dq_o  <= 8'h00;
         o_dq_oe <= 1'b0;
         o_hv_id <= 1'b0;
         rdat_q  <= 8'h00;
      end else begin
         case (st_q)
            S_IDLE: begin
               if (wr_cmd && !(is_wop && i_supply_low) && w_data_q[2:0] != `FCP_OP_NONE) begin
                  op_q   <= w_data_q[2:0];
                  step_q <= 2'h0;
                  hv_q   <= (w_data_q[2:0] == `FCP_OP_HVREAD) ||
                            (w_data_q[2:0] == `FCP_OP_PROTCHK);
                  rd_q   <= !is_wop;
                  o_ce_n <= 1'b0;
                  if (!is_wop) begin
                     o_oe_n  <= 1'b0;
                     o_we_n  <= 1'b1;
                     o_dq_oe <= 1'b0;
                     cnt_q   <= ACC_CYC - 8'h01;
                     st_q    <= S_RACC;
                     o_hv_id <= (w_data_q[2:0] != `FCP_OP_READ);
                     if (w_data_q[2:0] == `FCP_OP_PROTCHK) begin
                        o_addr <= {addr_q[`FCP_SEC_HI:`FCP_SEC_LO], `FCP_PROT_LOW};
                     end else begin
                        o_addr <= addr_q;
                     end
                  end else begin
                     o_oe_n <= 1'b1;
                     st_q   <= S_WSET;
                     if (w_data_q[2:0] == `FCP_OP_CMDSEQ || w_data_q[2:0] == `FCP_OP_IDSEQ) begin
                        o_addr <= UNLK_A1;
                        o_dq_o <= UNLK_D1;
                     end else if (w_data_q[2:0] == `FCP_OP_RESET) begin
                        o_addr <= addr_q;
                        o_dq_o <= cfg_q[7:0];
                     end else begin
                        o_addr <= addr_q;
                        o_dq_o <= wdat_q;
                     end
                     o_dq_oe <= 1'b1;
                  end
               end
            end
            S_WSET: begin
               o_we_n <= 1'b0;
               cnt_q  <= WP_CYC - 8'h01;
               st_q   <= S_WPUL;
            end
            S_WPUL: begin
               if (cnt_q == 8'h00) begin
                  o_we_n <= 1'b1;
                  st_q   <= S_WHLD;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            S_WHLD: begin
               o_ce_n  <= 1'b1;
               o_dq_oe <= 1'b0;
               cnt_q   <= GL_CYC - 8'h01;
               st_q    <= S_GAP;
            end
            S_RACC: begin
               if (cnt_q == 8'h00) begin
                  rdat_q  <= i_dq_i;
                  o_ce_n  <= 1'b1;
                  o_oe_n  <= 1'b1;
                  o_hv_id <= 1'b0;
                  cnt_q   <= GL_CYC - 8'h01;
                  st_q    <= S_GAP;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            S_GAP: begin
               if (cnt_q != 8'h00) begin
                  cnt_q <= cnt_q - 8'h01;
               end else if (rd_q && fail_hit_q) begin
                  op_q   <= `FCP_OP_RESET;
                  rd_q   <= 1'b0;
                  hv_q   <= 1'b0;
                  o_ce_n <= 1'b0;
                  o_addr <= addr_q;
                  o_dq_o <= cfg_q[7:0];
                  o_dq_oe <= 1'b1;
                  st_q   <= S_WSET;
               end else if (!rd_q && !last_step && !i_supply_low) begin
                  step_q  <= step_q + 2'h1;
                  o_ce_n  <= 1'b0;
                  o_dq_oe <= 1'b1;
                  st_q    <= S_WSET;
                  if (step_q == 2'h0) begin
                     o_addr <= UNLK_A2;
                     o_dq_o <= UNLK_D2;
                  end else begin
                     o_addr <= addr_q;
                     o_dq_o <= wdat_q;
                  end
               end else begin
                  st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Status flags, set wins over a write-one clear
   wire seq_end = (st_q == S_GAP) && (cnt_q == 8'h00);
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         fail_hit_q <= 1'b0;
         idm_q  <= 1'b0;
         fail_q <= 1'b0;
         ref_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         if (rd_end) begin
            fail_hit_q <= fail_hit;
         end else if (seq_end) begin
            fail_hit_q <= 1'b0;
         end
         if (seq_end && last_step && op_q == `FCP_OP_IDSEQ && !rd_q && !i_supply_low) begin
            idm_q <= 1'b1;
         end else if ((seq_end && op_q == `FCP_OP_RESET) || i_supply_low) begin
            idm_q <= 1'b0;
         end
         fail_q <= (fail_q & ~(clr_st & w_data_q[`FCP_ST_FAIL])) | (rd_end & fail_hit);
         ref_q  <= (ref_q & ~(clr_st & w_data_q[`FCP_ST_REFUSED])) |
                   (wr_cmd & (busy | (is_wop & i_supply_low)));
         done_q <= (done_q & ~(clr_st & w_data_q[`FCP_ST_DONE])) |
                   (seq_end & !(rd_q & fail_hit_q) & (rd_q | last_step | i_supply_low));
      end
   end

   // ==========================================================
   // Protection readback store, one entry per sector
   fcp_prot_mem u_pmem (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_we      (rd_end && op_q == `FCP_OP_PROTCHK),
      .i_waddr   (addr_q[`FCP_SEC_HI:`FCP_SEC_LO]),
      .i_wdata   (i_dq_i),
      .i_raddr   (psel_q),
      .o_rdata_q (pm_rdata)
   );
endmodule

/* File: tb/fcp_host_asserts.sv */
// Concurrent checks on the flash pins and bus handshakes of fcp_host.
// Assumes one clock domain and is bound onto every fcp_host instance.
`timescale 1ns/100ps
module fcp_host_asserts (
   input logic        i_clk_sys,
   input logic        i_rstn,
   input logic        o_awready,
   input logic        o_wready,
   input logic        o_bvalid,
   input logic        o_arready,
   input logic        o_rvalid,
   input logic [18:0] o_addr,
   input logic        o_ce_n,
   input logic        o_oe_n,
   input logic        o_we_n,
   input logic [7:0]  o_dq_o,
   input logic        o_dq_oe,
   input logic        o_hv_id
);
   // ==========================================================
   // Pin relations
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   a_oe_blocks_drive: assert property (o_dq_oe |-> o_oe_n)
      else $error("data driven while output enable low");
   a_write_levels: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
      else $error("write strobe with wrong control levels");
   a_read_levels: assert property (!o_oe_n |-> !o_ce_n && o_we_n && !o_dq_oe)
      else $error("read strobe with wrong control levels");
   a_pulse_width: assert property ($fell(o_we_n) |-> !o_we_n [*2] ##1 o_we_n)
      else $error("write pulse not two cycles");
   a_addr_steady: assert property (!o_we_n |-> $stable(o_addr) && $stable(o_dq_o))
      else $error("address or data moved in write pulse");
   a_ce_after_we: assert property ($rose(o_we_n) |-> !o_ce_n ##1 o_ce_n)
      else $error("chip enable not released after write enable");
   a_read_hold: assert property ($fell(o_oe_n) |-> !o_oe_n [*2] ##1 o_oe_n)
      else $error("read strobe not two cycles");
   a_hv_only_read: assert property (o_hv_id |-> o_we_n && !o_dq_oe)
      else $error("elevated id during a write");
   a_ce_gap: assert property ($rose(o_ce_n) |-> o_ce_n [*2])
      else $error("chip enable gap too short");
   // ==========================================================
   // Bus handshakes
   a_bresp_block: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write channels ready during response");
   a_rresp_block: assert property (o_rvalid |-> !o_arready)
      else $error("read address ready during response");
   c_write: cover property ($fell(o_we_n));
   c_hv_read: cover property ($fell(o_oe_n) && o_hv_id);
   c_plain_read: cover property ($fell(o_oe_n) && !o_hv_id);
endmodule
bind fcp_host fcp_host_asserts chk_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
   .o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid),
   .o_arready(o_arready), .o_rvalid(o_rvalid), .o_addr(o_addr), .o_ce_n(o_ce_n),
   .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_dq_o(o_dq_o), .o_dq_oe(o_dq_oe),
   .o_hv_id(o_hv_id));

/* File: tb/fcp_flash_model.sv */
// Behavioural byte-wide flash: array pattern, id codes, protection, reset.
// Assumes pin-level strobes from a host; no clock of its own.
`timescale 1ns/100ps
module fcp_flash_model #(
   parameter [18:0] UA1   = 19'h00000,
   parameter [7:0]  UD1   = 8'h00,
   parameter [18:0] UA2   = 19'h00000,
   parameter [7:0]  UD2   = 8'h00,
   parameter [7:0]  IDC   = 8'h90,
   parameter [7:0]  RSTC  = 8'hff,
   parameter [7:0]  MAKER = 8'h3c, // Arbitrary value
   parameter [7:0]  PART  = 8'hc3  // Arbitrary value
) (
   input  wire [18:0] i_addr,
   input  wire        i_ce_n,
   input  wire        i_oe_n,
   input  wire        i_we_n,
   input  wire [7:0]  i_dq,
   input  wire        i_hv_id,
   input  wire        i_supply_low,
   output wire [7:0]  o_dq
);
   reg [1:0]  st = 2'd0;
   reg [7:0]  prot = 8'h0;
   reg [18:0] la;
   reg [7:0]  last = 8'h0;
   realtime   t0;
   wire       wr_n = i_ce_n | i_we_n | ~i_oe_n;
   wire       rd_en = !i_ce_n && !i_oe_n && i_we_n;
   wire       idsel = i_hv_id || st == 2'd3;
   wire [7:0] rd = !idsel ? (i_addr[7:0] ^ {i_addr[18:16], 5'h0}) :
                   i_addr[1:0] == 2'd0 ? MAKER : i_addr[1:0] == 2'd1 ? PART :
                   {7'h0, prot[i_addr[18:16]]};
   assign o_dq = rd_en ? rd : ~last;
   always @* begin
      if (rd_en)
         last = rd;
   end
   always @(negedge wr_n) begin
      la = i_addr;
      t0 = $realtime;
   end
   always @(posedge wr_n) begin
      if (i_supply_low)
         st <= 2'd0;
      else if ($realtime - t0 < 5.0)
         st <= st;
      else if (i_dq == RSTC)
         st <= 2'd0;
      else if (st == 2'd0 && la == UA1 && i_dq == UD1)
         st <= 2'd1;
      else if (st == 2'd1 && la == UA2 && i_dq == UD2)
         st <= 2'd2;
      else if (st == 2'd2 && i_dq == IDC)
         st <= 2'd3;
      else if (st != 2'd3)
         st <= 2'd0;
   end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for fcp_host against the behavioural flash.
// Assumes AXI4-Lite register map and op codes from fcp_consts.vh.
`timescale 1ns/100ps
`include "fcp_consts.vh"
module tb_top;
   localparam [18:0] UA1 = 19'h00555; // Arbitrary unlock values
   localparam [18:0] UA2 = 19'h002aa;
   reg         clk = 1'b0;
   reg         rstn = 1'b0;
   reg  [7:0]  awaddr = 8'h0;
   reg         awvalid = 1'b0;
   reg  [31:0] wdata = 32'h0;
   reg         wvalid = 1'b0;
   reg         bready = 1'b0;
   reg  [7:0]  araddr = 8'h0;
   reg         arvalid = 1'b0;
   reg         rready = 1'b0;
   reg         low = 1'b0;
   reg  [1:0]  resp;
   reg  [31:0] rv;
   integer     n_fail = 0;
   integer     checks = 0;
   integer     s;
   wire        awready, wready, bvalid, arready, rvalid;
   wire        ce_n, oe_n, we_n, dq_oe, hv_id;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [18:0] addr;
   wire [7:0]  dq_o, dq_i;
   always #25 clk = ~clk;
   fcp_host #(.UNLK_A1(UA1), .UNLK_D1(8'haa), .UNLK_A2(UA2), .UNLK_D2(8'h55)) dut_u (
      .i_clk_sys(clk), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_addr(addr),
      .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_dq_o(dq_o), .o_dq_oe(dq_oe),
      .i_dq_i(dq_i), .o_hv_id(hv_id), .i_supply_low(low));
   fcp_flash_model #(.UA1(UA1), .UD1(8'haa), .UA2(UA2), .UD2(8'h55)) flash_u (
      .i_addr(addr), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(dq_o),
      .i_hv_id(hv_id), .i_supply_low(low), .o_dq(dq_i));
   // ==========================================================
   // Shared tasks
   task summarize;
      begin
         if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task tmo;
      begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: timeout", $time);
         summarize;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task axi_wr(input [7:0] a, input [31:0] d);
      integer n;
      reg     dn;
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         dn = 1'b0;
         for (n = 0; !dn; n = n + 1) begin
            if (n > 200)
               tmo;
            @(posedge clk);
            if (awready)
               awvalid <= 1'b0;
            if (wready)
               wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
               resp = bresp;
               bready <= 1'b0;
               dn = 1'b1;
            end
         end
      end
   endtask
   task axi_rd(input [7:0] a);
      integer n;
      reg     dn;
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         dn = 1'b0;
         for (n = 0; !dn; n = n + 1) begin
            if (n > 200)
               tmo;
            @(posedge clk);
            if (arready)
               arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
               rv = rdata;
               resp = rresp;
               rready <= 1'b0;
               dn = 1'b1;
            end
         end
      end
   endtask
   task do_op(input [2:0] op);
      integer n;
      begin
         axi_wr(`FCP_REG_CMD, {29'h0, op});
         rv = 32'h0;
         for (n = 0; rv[`FCP_ST_DONE] !== 1'b1; n = n + 1) begin
            if (n > 50)
               tmo;
            axi_rd(`FCP_REG_STATUS);
         end
         axi_wr(`FCP_REG_STATUS, 32'h1c);
      end
   endtask
   task op_rd(input [2:0] op, input [18:0] a, input [7:0] exp);
      begin
         axi_wr(`FCP_REG_ADDR, {13'h0, a});
         do_op(op);
         axi_rd(`FCP_REG_RDATA);
         chk(rv, {24'h0, exp});
      end
   endtask
   // ==========================================================
   // Scenarios
   task t_reset;
      begin
         axi_rd(`FCP_REG_STATUS);
         chk(rv, 32'h0);
         axi_rd(`FCP_REG_CFG);
         chk({23'h0, rv[8:0]}, 32'h0ff);
         axi_wr(8'h3c, 32'h0);
         chk({30'h0, resp}, 32'h2);
         axi_rd(8'h3c);
         chk({30'h0, resp}, 32'h2);
      end
   endtask
   task t_array;
      begin
         for (s = 0; s < 8; s = s + 1)
            op_rd(`FCP_OP_READ, {s[2:0], 16'h0012}, 8'h12 ^ {s[2:0], 5'h0});
      end
   endtask
   task t_hv;
      begin
         op_rd(`FCP_OP_HVREAD, 19'h0, 8'h3c);
         op_rd(`FCP_OP_HVREAD, 19'h1, 8'hc3);
         op_rd(`FCP_OP_PROTCHK, 19'h20000, 8'h0);
         flash_u.prot[2] = 1'b1;
         op_rd(`FCP_OP_PROTCHK, 19'h20000, 8'h1);
         op_rd(`FCP_OP_PROTCHK, 19'h30000, 8'h0);
         axi_wr(`FCP_REG_PSEL, 32'h200);
         axi_rd(`FCP_REG_PSEL);
         chk({21'h0, rv[10:0]}, 32'h201);
      end
   endtask
   task t_idseq;
      begin
         axi_wr(`FCP_REG_ADDR, {13'h0, UA1});
         axi_wr(`FCP_REG_WDATA, 32'h90);
         do_op(`FCP_OP_IDSEQ);
         axi_rd(`FCP_REG_STATUS);
         chk({31'h0, rv[`FCP_ST_IDMODE]}, 32'h1);
         op_rd(`FCP_OP_READ, 19'h0, 8'h3c);
         op_rd(`FCP_OP_READ, 19'h1, 8'hc3);
         op_rd(`FCP_OP_READ, 19'h20002, 8'h1);
         op_rd(`FCP_OP_READ, 19'h40002, 8'h0);
         axi_wr(`FCP_REG_ADDR, 32'h71234);
         do_op(`FCP_OP_RESET);
         axi_rd(`FCP_REG_STATUS);
         chk({31'h0, rv[`FCP_ST_IDMODE]}, 32'h0);
         op_rd(`FCP_OP_READ, 19'h50012, 8'hb2);
      end
   endtask
   task t_auto;
      begin
         axi_wr(`FCP_REG_ADDR, {13'h0, UA1});
         axi_wr(`FCP_REG_WDATA, 32'h90);
         do_op(`FCP_OP_IDSEQ);
         axi_wr(`FCP_REG_CFG, 32'h1ff);
         axi_wr(`FCP_REG_ADDR, 32'h0);
         do_op(`FCP_OP_READ);
         chk({31'h0, rv[`FCP_ST_FAIL]}, 32'h1);
         chk({31'h0, rv[`FCP_ST_IDMODE]}, 32'h0);
         axi_rd(`FCP_REG_RDATA);
         chk(rv, 32'h3c);
         op_rd(`FCP_OP_READ, 19'h0, 8'h00);
         axi_wr(`FCP_REG_CFG, 32'h0ff);
      end
   endtask
   task t_abort;
      begin
         axi_wr(`FCP_REG_ADDR, 32'h31111);
         axi_wr(`FCP_REG_WDATA, 32'hff);
         do_op(`FCP_OP_CMDSEQ);
         op_rd(`FCP_OP_READ, 19'h10040, 8'h60);
      end
   endtask
   task t_low;
      begin
         low <= 1'b1;
         axi_wr(`FCP_REG_CMD, {29'h0, `FCP_OP_WRITE});
         axi_rd(`FCP_REG_STATUS);
         chk({31'h0, rv[`FCP_ST_REFUSED]}, 32'h1);
         axi_wr(`FCP_REG_STATUS, 32'h1c);
         low <= 1'b0;
         op_rd(`FCP_OP_READ, 19'h60003, 8'hc3);
         do_op(`FCP_OP_WRITE);
         chk({31'h0, rv[`FCP_ST_REFUSED]}, 32'h0);
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset;
      t_array;
      t_hv;
      t_idseq;
      t_auto;
      t_abort;
      t_low;
      summarize;
   end
endmodule
